// File: src/extended_memory_op_executor.sv
// Extended data memory operation executor with APB register access
// Notes on behaviour
// - Operand address is a full flat address, no bank selection.
// - Move copies accumulator into memory, flags untouched.
// - OR of accumulator and memory to accumulator or memory; only Z.
// - Rotate left moves bit 7 into bit 0, no flags.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Rotate right moves bit 0 into bit 7, no flags.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Accumulator forms of rotates leave memory unchanged.
// - Subtract with borrow: acc minus mem minus not carry, six flags.
// - Subtract carry is 0 when negative, 1 when zero or positive.
// - Plain subtract: acc minus mem, same six flags.
// - Decrement memory, write back, skip when zero, no flags.
// - Accumulator skip forms write only accumulator, skip on it zero.
// - Increment memory, write back, skip when it wraps to zero.
// - Every conditional skip op lasts three cycles.
// - Byte set loads all ones, no flags.
// - Bit set forces only the chosen bit to one, no flags.
// - Bit test skips when chosen bit is one, no flags.
// - Byte test writes value back, skips when nonzero, no flags.
// - Nibble swap exchanges the halves in place, no flags.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "extended_memory_op_cfg.svh"

module extended_memory_op_executor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execution status
  output logic busy,
  output logic skip
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] mem_r [0:(1<<ADDR_W)-1];
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [5:0] flags_r;
  logic [5:0] flags_nxt;
  logic [ADDR_W-1:0] maddr_r;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0] bit_q;
  extended_memory_op_pkg::op_t op_q;
  extended_memory_op_pkg::state_t state_r;
  extended_memory_op_pkg::state_t state_nxt;
  logic [7:0] mem_rd;
  logic mem_we;
  logic [7:0] mem_wd;
  logic is_skip;
  logic skip_hit;
  logic ex;
  logic setup;
  logic access;
  logic sel_err;
  logic [31:0] rd_mux;
  logic cmd_go;
  logic wr_ok;
  logic [11:0] sub_res;
  logic sub_borrow;
  logic [8:0] rot_res;
  logic [7:0] step_res;

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Returns {ov, sc, ac, c, result}
  function automatic logic [11:0] sub_calc(input logic [7:0] a,
                                           input logic [7:0] m,
                                           input logic b);
    logic [8:0] d;
    logic [4:0] n;
    logic ov;
    d = {1'b0, a} - {1'b0, m} - {8'h00, b};
    n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, b};
    ov = (a[7] ^ m[7]) & (d[7] ^ a[7]);
    sub_calc = {ov, ~(ov ^ d[7]), ~n[4], ~d[8], d[7:0]};
  endfunction : sub_calc

  // Returns {carry out, rotated byte}
  function automatic logic [8:0] rot_calc(input logic [7:0] d,
                                          input logic left,
                                          input logic thru,
                                          input logic cin);
    logic fill;
    if (left) begin
      fill = thru ? cin : d[7];
      rot_calc = {d[7], d[6:0], fill};
    end else begin
      fill = thru ? cin : d[0];
      rot_calc = {d[0], fill, d[7:1]};
    end
  endfunction : rot_calc

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign ex = (state_r == extended_memory_op_pkg::st_exec);
  assign wr_ok = access & pwrite & ~pslverr;
  assign cmd_go = wr_ok & (paddr == `OFS_CMD);

  always_comb begin
    rd_mux = 32'h0000_0000;
    sel_err = 1'b0;
    unique case (paddr)
      `OFS_CMD: begin
        rd_mux[`CMD_OP_MSB:`CMD_OP_LSB] = op_q;
        rd_mux[`CMD_BIT_MSB:`CMD_BIT_LSB] = bit_q;
        rd_mux[`CMD_ADDR_LSB +: ADDR_W] = addr_q;
        sel_err = pwrite & (pstrb != 4'hf);
      end
      `OFS_ACC: begin
        rd_mux[7:0] = acc_r;
        sel_err = pwrite & ~pstrb[0];
      end
      `OFS_FLAGS: begin
        rd_mux[5:0] = flags_r;
        sel_err = pwrite & ~pstrb[0];
      end
      `OFS_MADDR: begin
        rd_mux[ADDR_W-1:0] = maddr_r;
        sel_err = pwrite & ~pstrb[0];
      end
      `OFS_MDATA: begin
        rd_mux[7:0] = mem_r[maddr_r];
        sel_err = pwrite & ~pstrb[0];
      end
      `OFS_STAT: begin
        rd_mux[`STAT_BUSY] = busy;
        rd_mux[`STAT_SKIP] = skip;
        sel_err = pwrite;
      end
      default: sel_err = 1'b1;
    endcase
    // Writes while an op runs would race the datapath, so refuse them
    if (pwrite & busy) begin
      sel_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= sel_err;
        prdata <= sel_err ? 32'h0000_0000 : rd_mux;
      end else if (access) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_r <= ADDR_W'(`MADDR_RST);
    end else if (wr_ok & (paddr == `OFS_MADDR)) begin
      maddr_r <= pwdata[ADDR_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= extended_memory_op_pkg::long_move;
      bit_q <= 3'h0;
      addr_q <= '0;
    end else if (cmd_go) begin
      op_q <= extended_memory_op_pkg::op_t'(
        pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
      bit_q <= pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
      addr_q <= pwdata[`CMD_ADDR_LSB +: ADDR_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath

  assign mem_rd = mem_r[addr_q];
  assign sub_borrow = (op_q == extended_memory_op_pkg::subtract_borrow_to_acc)
    | (op_q == extended_memory_op_pkg::subtract_borrow_to_mem)
    ? ~flags_r[`FLG_C] : 1'b0;
  // borrow is the complement of carry
  assign sub_res = sub_calc(acc_r, mem_rd, sub_borrow);

  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    mem_we = 1'b0;
    mem_wd = mem_rd;
    is_skip = 1'b0;
    skip_hit = 1'b0;
    rot_res = 9'h000;
    step_res = 8'h00;
    unique case (op_q)
      extended_memory_op_pkg::long_move: begin
        mem_we = 1'b1;
        mem_wd = acc_r;
      end
      extended_memory_op_pkg::long_or_to_acc,
      extended_memory_op_pkg::long_or_to_mem: begin
        step_res = acc_r | mem_rd;
        flags_nxt[`FLG_Z] = (step_res == 8'h00);
        if (op_q == extended_memory_op_pkg::long_or_to_acc) begin
          acc_nxt = step_res;
        end else begin
          mem_we = 1'b1;
          mem_wd = step_res;
        end
      end
      extended_memory_op_pkg::rotate_left_mem,
      extended_memory_op_pkg::rotate_left_to_acc,
      extended_memory_op_pkg::rotate_left_carry_mem,
      extended_memory_op_pkg::rotate_left_carry_to_acc,
      extended_memory_op_pkg::rotate_right_mem,
      extended_memory_op_pkg::rotate_right_to_acc,
      extended_memory_op_pkg::rotate_right_carry_mem,
      extended_memory_op_pkg::rotate_right_carry_to_acc: begin
        rot_res = rot_calc(mem_rd,
          op_q <= extended_memory_op_pkg::rotate_left_carry_to_acc,
          (op_q == extended_memory_op_pkg::rotate_left_carry_mem) |
          (op_q == extended_memory_op_pkg::rotate_left_carry_to_acc) |
          (op_q == extended_memory_op_pkg::rotate_right_carry_mem) |
          (op_q == extended_memory_op_pkg::rotate_right_carry_to_acc),
          flags_r[`FLG_C]);
        if ((op_q == extended_memory_op_pkg::rotate_left_carry_mem) |
            (op_q == extended_memory_op_pkg::rotate_left_carry_to_acc) |
            (op_q == extended_memory_op_pkg::rotate_right_carry_mem) |
            (op_q == extended_memory_op_pkg::rotate_right_carry_to_acc))
        begin
          flags_nxt[`FLG_C] = rot_res[8];
        end
        if ((op_q == extended_memory_op_pkg::rotate_left_to_acc) |
            (op_q == extended_memory_op_pkg::rotate_left_carry_to_acc) |
            (op_q == extended_memory_op_pkg::rotate_right_to_acc) |
            (op_q == extended_memory_op_pkg::rotate_right_carry_to_acc))
        begin
          acc_nxt = rot_res[7:0];
        end else begin
          mem_we = 1'b1;
          mem_wd = rot_res[7:0];
        end
      end
      extended_memory_op_pkg::subtract_borrow_to_acc,
      extended_memory_op_pkg::subtract_borrow_to_mem,
      extended_memory_op_pkg::subtract_to_acc,
      extended_memory_op_pkg::subtract_to_mem: begin
        flags_nxt[`FLG_OV] = sub_res[11];
        flags_nxt[`FLG_SC] = sub_res[10];
        flags_nxt[`FLG_AC] = sub_res[9];
        flags_nxt[`FLG_C] = sub_res[8];
        flags_nxt[`FLG_Z] = (sub_res[7:0] == 8'h00);
        // Borrow form chains zero across bytes only when the old carry is 0
        flags_nxt[`FLG_CZ] = (sub_res[7:0] == 8'h00) &
          (sub_borrow | ~flags_r[`FLG_C] ? flags_r[`FLG_CZ] : 1'b1);
        if ((op_q == extended_memory_op_pkg::subtract_to_acc) |
            (op_q == extended_memory_op_pkg::subtract_borrow_to_acc))
        begin
          acc_nxt = sub_res[7:0];
        end else begin
          mem_we = 1'b1;
          mem_wd = sub_res[7:0];
        end
        if ((op_q == extended_memory_op_pkg::subtract_to_acc) |
            (op_q == extended_memory_op_pkg::subtract_to_mem)) begin
          flags_nxt[`FLG_CZ] = (sub_res[7:0] == 8'h00);
        end
      end
      extended_memory_op_pkg::decrement_skip_zero,
      extended_memory_op_pkg::decrement_skip_zero_acc,
      extended_memory_op_pkg::increment_skip_zero,
      extended_memory_op_pkg::increment_skip_zero_acc: begin
        is_skip = 1'b1;
        if ((op_q == extended_memory_op_pkg::decrement_skip_zero) |
            (op_q == extended_memory_op_pkg::decrement_skip_zero_acc))
        begin
          step_res = mem_rd - 8'h01;
        end else begin
          step_res = mem_rd + 8'h01;
        end
        skip_hit = (step_res == 8'h00);
        if ((op_q == extended_memory_op_pkg::decrement_skip_zero_acc) |
            (op_q == extended_memory_op_pkg::increment_skip_zero_acc))
        begin
          acc_nxt = step_res;
        end else begin
          mem_we = 1'b1;
          mem_wd = step_res;
        end
      end
      extended_memory_op_pkg::set_all_bits: begin
        mem_we = 1'b1;
        mem_wd = 8'hff;
      end
      extended_memory_op_pkg::set_one_bit: begin
        mem_we = 1'b1;
        mem_wd = mem_rd | (8'h01 << bit_q);
      end
      extended_memory_op_pkg::skip_if_bit_nonzero: begin
        is_skip = 1'b1;
        skip_hit = mem_rd[bit_q];
      end
      extended_memory_op_pkg::skip_if_nonzero: begin
        is_skip = 1'b1;
        mem_we = 1'b1;
        skip_hit = (mem_rd != 8'h00);
      end
      extended_memory_op_pkg::nibble_exchange: begin
        mem_we = 1'b1;
        mem_wd = {mem_rd[3:0], mem_rd[7:4]};
      end
      // Unused opcodes run as a one-cycle no-op
      default: ;
    endcase
  end

  // Data memory has no reset; software loads it before use
  always_ff @(posedge pclk) begin
    if (ex & mem_we) begin
      mem_r[addr_q] <= mem_wd;
    end else if (wr_ok & (paddr == `OFS_MDATA)) begin
      mem_r[maddr_r] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `ACC_RST;
    end else if (ex) begin
      acc_r <= acc_nxt;
    end else if (wr_ok & (paddr == `OFS_ACC)) begin
      acc_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `FLAGS_RST;
    end else if (ex) begin
      flags_r <= flags_nxt;
    end else if (wr_ok & (paddr == `OFS_FLAGS)) begin
      flags_r <= pwdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencing

  // skip ops take exec, fetch and dummy cycles
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      extended_memory_op_pkg::st_idle:
        if (cmd_go) state_nxt = extended_memory_op_pkg::st_exec;
      extended_memory_op_pkg::st_exec:
        state_nxt = is_skip ? extended_memory_op_pkg::st_fetch
                            : extended_memory_op_pkg::st_idle;
      extended_memory_op_pkg::st_fetch:
        state_nxt = extended_memory_op_pkg::st_dummy;
      extended_memory_op_pkg::st_dummy:
        state_nxt = extended_memory_op_pkg::st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= extended_memory_op_pkg::st_idle;
      busy <= 1'b0;
      skip <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy <= (state_nxt != extended_memory_op_pkg::st_idle);
      if (cmd_go) begin
        skip <= 1'b0;
      end else if (ex) begin
        skip <= is_skip & skip_hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence skip_start;
    ex && is_skip;
  endsequence

  sequence three_busy;
    busy[*3] ##1 !busy;
  endsequence

  skip_three_a: assert property (skip_start |-> three_busy)
    else $error("skip op did not last three cycles");
  plain_one_a: assert property (ex && !is_skip |=> !busy)
    else $error("non-skip op did not end after one cycle");
  move_copy_a: assert property (
    ex && op_q == extended_memory_op_pkg::long_move
    |=> mem_r[addr_q] == $past(acc_r) && $stable(flags_r))
    else $error("move did not copy accumulator or touched flags");
  or_zero_a: assert property (
    ex && op_q == extended_memory_op_pkg::long_or_to_acc
    |=> acc_r == ($past(acc_r) | $past(mem_rd))
        && flags_r[`FLG_Z] == (acc_r == 8'h00)
        && flags_r[`FLG_C] == $past(flags_r[`FLG_C]))
    else $error("OR result or zero flag wrong");
  rotl_wrap_a: assert property (
    ex && op_q == extended_memory_op_pkg::rotate_left_mem
    |=> mem_r[addr_q] == {$past(mem_rd[6:0]), $past(mem_rd[7])}
        && $stable(flags_r))
    else $error("rotate left wrong");
  rotlc_carry_a: assert property (
    ex && op_q == extended_memory_op_pkg::rotate_left_carry_mem
    |=> mem_r[addr_q] == {$past(mem_rd[6:0]), $past(flags_r[`FLG_C])}
        && flags_r[`FLG_C] == $past(mem_rd[7]))
    else $error("rotate left through carry wrong");
  rotr_wrap_a: assert property (
    ex && op_q == extended_memory_op_pkg::rotate_right_mem
    |=> mem_r[addr_q] == {$past(mem_rd[0]), $past(mem_rd[7:1])})
    else $error("rotate right wrong");
  rotrc_carry_a: assert property (
    ex && op_q == extended_memory_op_pkg::rotate_right_carry_to_acc
    |=> acc_r == {$past(flags_r[`FLG_C]), $past(mem_rd[7:1])}
        && flags_r[`FLG_C] == $past(mem_rd[0]) && $stable(mem_rd))
    else $error("rotate right through carry wrong");
  sub_carry_a: assert property (
    ex && op_q == extended_memory_op_pkg::subtract_to_acc
    |=> flags_r[`FLG_C] == ($past(acc_r) >= $past(mem_rd))
        && acc_r == $past(acc_r) - $past(mem_rd))
    else $error("subtract carry or result wrong");
  dec_skip_a: assert property (
    ex && op_q == extended_memory_op_pkg::decrement_skip_zero
    |=> mem_r[addr_q] == $past(mem_rd) - 8'h01
        && skip == (mem_r[addr_q] == 8'h00) && $stable(flags_r))
    else $error("decrement skip wrong");
  bit_set_a: assert property (
    ex && op_q == extended_memory_op_pkg::set_one_bit
    |=> mem_r[addr_q] == ($past(mem_rd) | (8'h01 << bit_q)))
    else $error("bit set wrong");
  swap_nib_a: assert property (
    ex && op_q == extended_memory_op_pkg::nibble_exchange
    |=> mem_r[addr_q] == {$past(mem_rd[3:0]), $past(mem_rd[7:4])})
    else $error("nibble swap wrong");

endmodule : extended_memory_op_executor

// File: src/extended_memory_op_cfg.svh
// Register map, field positions and reset values of the extended op executor
`ifndef EXTENDED_MEMORY_OP_CFG_SVH
`define EXTENDED_MEMORY_OP_CFG_SVH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_ACC 8'h04
`define OFS_FLAGS 8'h08
`define OFS_MADDR 8'h0c
`define OFS_MDATA 8'h10
`define OFS_STAT 8'h14

// Command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 4
`define CMD_BIT_LSB 8
`define CMD_BIT_MSB 10
`define CMD_ADDR_LSB 16

// Flag register bit positions
`define FLG_C 0
`define FLG_AC 1
`define FLG_Z 2
`define FLG_OV 3
`define FLG_SC 4
`define FLG_CZ 5

// Status register bit positions
`define STAT_BUSY 0
`define STAT_SKIP 1

// Reset values
`define ACC_RST 8'h00
`define FLAGS_RST 6'h00
`define MADDR_RST 16'h0000

`endif

// File: src/extended_memory_op_pkg.sv
// Types shared by the extended op executor
package extended_memory_op_pkg;

  typedef enum logic [4:0] {
    long_move                 = 5'h00,
    long_or_to_acc            = 5'h01,
    long_or_to_mem            = 5'h02,
    rotate_left_mem           = 5'h03,
    rotate_left_to_acc        = 5'h04,
    rotate_left_carry_mem     = 5'h05,
    rotate_left_carry_to_acc  = 5'h06,
    rotate_right_mem          = 5'h07,
    rotate_right_to_acc       = 5'h08,
    rotate_right_carry_mem    = 5'h09,
    rotate_right_carry_to_acc = 5'h0a,
    subtract_borrow_to_acc    = 5'h0b,
    subtract_borrow_to_mem    = 5'h0c,
    decrement_skip_zero       = 5'h0d,
    decrement_skip_zero_acc   = 5'h0e,
    set_all_bits              = 5'h0f,
    set_one_bit               = 5'h10,
    increment_skip_zero       = 5'h11,
    increment_skip_zero_acc   = 5'h12,
    skip_if_bit_nonzero       = 5'h13,
    skip_if_nonzero           = 5'h14,
    subtract_to_acc           = 5'h15,
    subtract_to_mem           = 5'h16,
    nibble_exchange           = 5'h17
  } op_t;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_exec  = 2'b01,
    st_fetch = 2'b10,
    st_dummy = 2'b11
  } state_t;

endpackage : extended_memory_op_pkg

// File: bench/extended_memory_op_executor_tb.sv
// Self-checking testbench for the extended memory op executor
`timescale 1ns/1ps
`include "extended_memory_op_cfg.svh"

module extended_memory_op_executor_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic skip;
  int fail_count;
  int checked;
  int cycles;

  extended_memory_op_executor dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .skip(skip)
  );

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // Loads operands, runs one op, then checks timing, skip and all results
  task run(input logic [4:0] op, input logic [2:0] bs,
           input logic [7:0] ad, a, m, input logic [5:0] fl,
           input logic [7:0] ea, em, input logic [5:0] ef, input logic es);
    logic [31:0] r;
    logic [31:0] c;
    logic [31:0] n;
    logic sk;
    sk = op inside {5'h0d, 5'h0e, 5'h11, 5'h12, 5'h13, 5'h14};
    c = 32'h0;
    c[4:0] = op;
    c[10:8] = bs;
    c[`CMD_ADDR_LSB +: 8] = ad;
    wr(`OFS_MADDR, {24'h0, ad});
    wr(`OFS_MDATA, {24'h0, m});
    wr(`OFS_ACC, {24'h0, a});
    wr(`OFS_FLAGS, {26'h0, fl});
    wr(`OFS_CMD, c);
    n = 32'h0;
    @(posedge pclk);
    while (busy === 1'b1 && n < 32'h8) begin
      n++;
      @(posedge pclk);
    end
    chk("busy cycles", sk ? 32'h3 : 32'h1, n);
    chk("skip", {31'h0, es}, {31'h0, skip});
    rd(`OFS_ACC, r);
    chk("acc", {24'h0, ea}, r);
    rd(`OFS_FLAGS, r);
    chk("flags", {26'h0, ef}, r);
    rd(`OFS_MDATA, r);
    chk("mem", {24'h0, em}, r);
  endtask : run

  function automatic logic [13:0] sub_ref(input logic [7:0] a, m,
                                          input logic cin, cz0, brw);
    logic [8:0] d;
    logic [4:0] h;
    logic b;
    logic z;
    logic ov;
    b = brw & ~cin;
    d = {1'b0, a} - {1'b0, m} - {8'h0, b};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, b};
    z = (d[7:0] == 8'h00);
    ov = (a[7] != m[7]) && (d[7] != a[7]);
    return {d[7:0], brw ? (z & cz0) : z, ~(ov ^ d[7]), ov, z, ~h[4], ~d[8]};
  endfunction : sub_ref

  ////////////////////////////////////////////////////////////////////////////
  task t_move_or;
    run(extended_memory_op_pkg::long_move, 3'h0, 8'hff, 8'h5a, 8'hc3,
        6'h3f, 8'h5a, 8'h5a, 6'h3f, 1'b0);
    run(extended_memory_op_pkg::long_or_to_acc, 3'h0, 8'h10, 8'h00, 8'h00,
        6'h00, 8'h00, 8'h00, 6'h04, 1'b0);
    run(extended_memory_op_pkg::long_or_to_mem, 3'h0, 8'h11, 8'ha0, 8'h05,
        6'h3f, 8'ha0, 8'ha5, 6'h3b, 1'b0);
  endtask : t_move_or

  // Both carry values so a stuck carry input shows up
  task t_rotate;
    logic [7:0] m;
    logic [7:0] r;
    logic [5:0] fl;
    logic nc;
    for (int j = 0; j < 2; j++) begin
      m = j[0] ? 8'h7e : 8'h81;
      fl = {5'b10100, j[0]};
      for (int i = 0; i < 8; i++) begin
        r = !i[2] ? {m[6:0], i[1] ? fl[0] : m[7]}
                  : {i[1] ? fl[0] : m[0], m[7:1]};
        nc = i[1] ? (!i[2] ? m[7] : m[0]) : fl[0];
        run(5'h03 + 5'(i), 3'h0, 8'hf0 + 8'(i), 8'h33, m, fl,
            i[0] ? r : 8'h33, i[0] ? m : r, {fl[5:1], nc},
            1'b0);
      end
    end
  endtask : t_rotate

  task t_subtract;
    logic [7:0] av [4];
    logic [7:0] mv [4];
    logic [4:0] ops [4];
    logic [13:0] x;
    logic brw;
    logic toa;
    av = '{8'h50, 8'h30, 8'h80, 8'h44};
    mv = '{8'h30, 8'h50, 8'h01, 8'h44};
    ops = '{5'h0b, 5'h0c, 5'h15, 5'h16};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        brw = (i < 2);
        toa = !i[0];
        x = sub_ref(av[k], mv[k], k[1] ^ k[0], k[0], brw);
        run(ops[i], 3'h0, 8'h40, av[k], mv[k], {k[0], 4'h0, k[1] ^ k[0]},
            toa ? x[13:6] : av[k], toa ? mv[k] : x[13:6], x[5:0],
            1'b0);
      end
    end
  endtask : t_subtract

  task t_skip_count;
    run(extended_memory_op_pkg::decrement_skip_zero, 3'h0, 8'h01, 8'h11,
        8'h01, 6'h3f, 8'h11, 8'h00, 6'h3f, 1'b1);
    run(extended_memory_op_pkg::decrement_skip_zero, 3'h0, 8'h02, 8'h11,
        8'h05, 6'h00, 8'h11, 8'h04, 6'h00, 1'b0);
    run(extended_memory_op_pkg::decrement_skip_zero_acc, 3'h0, 8'h03,
        8'h11, 8'h01, 6'h2a, 8'h00, 8'h01, 6'h2a, 1'b1);
    run(extended_memory_op_pkg::decrement_skip_zero_acc, 3'h0, 8'h04,
        8'h11, 8'h00, 6'h15, 8'hff, 8'h00, 6'h15, 1'b0);
    run(extended_memory_op_pkg::increment_skip_zero, 3'h0, 8'h05, 8'h22,
        8'hff, 6'h3f, 8'h22, 8'h00, 6'h3f, 1'b1);
    run(extended_memory_op_pkg::increment_skip_zero, 3'h0, 8'h06, 8'h22,
        8'h7f, 6'h00, 8'h22, 8'h80, 6'h00, 1'b0);
    run(extended_memory_op_pkg::increment_skip_zero_acc, 3'h0, 8'h07,
        8'h22, 8'hff, 6'h3f, 8'h00, 8'hff, 6'h3f, 1'b1);
  endtask : t_skip_count

  task t_set_test_swap;
    logic [7:0] m;
    run(extended_memory_op_pkg::set_all_bits, 3'h0, 8'h20, 8'h00, 8'h12,
        6'h15, 8'h00, 8'hff, 6'h15, 1'b0);
    for (int i = 0; i < 8; i++) begin
      m = 8'ha5 ^ (8'h01 << i);
      run(extended_memory_op_pkg::set_one_bit, 3'(i), 8'h21, 8'h00, m,
          6'h2a, 8'h00, m | (8'h01 << i), 6'h2a, 1'b0);
      run(extended_memory_op_pkg::skip_if_bit_nonzero, 3'(i), 8'h22, 8'h00,
          8'h10, 6'h3f, 8'h00, 8'h10, 6'h3f, i == 4);
    end
    run(extended_memory_op_pkg::skip_if_nonzero, 3'h0, 8'h23, 8'h01, 8'h00,
        6'h3f, 8'h01, 8'h00, 6'h3f, 1'b0);
    run(extended_memory_op_pkg::skip_if_nonzero, 3'h0, 8'h24, 8'h01, 8'h07,
        6'h00, 8'h01, 8'h07, 6'h00, 1'b1);
    run(extended_memory_op_pkg::nibble_exchange, 3'h0, 8'h25, 8'h55, 8'h3c,
        6'h3f, 8'h55, 8'hc3, 6'h3f, 1'b0);
  endtask : t_set_test_swap

  // Reset values first, then accesses that must be refused
  task t_reset_refuse;
    logic [31:0] r;
    logic e;
    rd(`OFS_ACC, r);
    chk("acc reset", {24'h0, `ACC_RST}, r);
    rd(`OFS_FLAGS, r);
    chk("flags reset", {26'h0, `FLAGS_RST}, r);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    apb(1'b1, `OFS_STAT, 32'h3, r, e);
    chk("status write error", 32'h1, {31'h0, e});
  endtask : t_reset_refuse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole run is under two thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_refuse();
    t_move_or();
    t_rotate();
    t_subtract();
    t_skip_count();
    t_set_test_swap();
    close_out();
  end
endmodule : extended_memory_op_executor_tb
